// *** hw/slcr_pkg.sv ***
package slcr_pkg;
	// ==========================================================
	// Register map
	localparam logic [11:0] LINK_ENABLE_ADDR    = 12'h0200;
	localparam logic [11:0] LINK_MODE_ADDR      = 12'h0201;
	localparam logic [11:0] MULTIFRAME_LEN_ADDR = 12'h0202;
	localparam logic [11:0] SOFT_SYNC_ADDR      = 12'h0203;
	localparam logic [11:0] LINK_CONTROL_ADDR   = 12'h0204;
	// ==========================================================
	// Reset values
	localparam logic [7:0] LINK_ENABLE_RST    = 8'h01;
	localparam logic [7:0] LINK_MODE_RST      = 8'h02;
	localparam logic [7:0] MULTIFRAME_LEN_RST = 8'h1f;
	localparam logic [7:0] SOFT_SYNC_RST      = 8'h01;
	localparam logic [7:0] LINK_CONTROL_RST   = 8'h02;
	// ==========================================================
	// Field positions
	localparam int LINK_ENABLE_BIT   = 0;
	localparam int MODE_MSB          = 4;
	localparam int KM_MSB            = 4;
	localparam int SOFT_SYNC_BIT     = 0;
	localparam int SYNC_SEL_MSB      = 3;
	localparam int SYNC_SEL_LSB      = 2;
	localparam int SAMPLE_FORMAT_BIT = 1;
	localparam int SCRAMBLER_BIT     = 0;
	// ==========================================================
	// Sync source codes
	localparam logic [1:0] SYNC_SRC_PIN  = 2'h0;
	localparam logic [1:0] SYNC_SRC_DIFF = 2'h1;
	localparam logic [1:0] SYNC_SRC_SOFT = 2'h2;
	// Register access states.
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_WRITE = 3'b010,
		ST_READ  = 3'b100
	} slcr_host_state_type;
endpackage

// *** hw/slcr_if.sv ***
`timescale 1ns/1ps
interface slcr_if;
	logic        wr_en;
	logic        rd_en;
	logic [11:0] addr;
	logic [7:0]  wdata;
	logic [7:0]  rdata;
	logic        rvalid;
	modport device (
		input  wr_en, rd_en, addr, wdata,
		output rdata, rvalid
	);
	modport host (
		output wr_en, rd_en, addr, wdata,
		input  rdata, rvalid
	);
endinterface

// *** hw/slcr_regs.sv ***
`timescale 1ns/1ps
// Summary of operation
// - Enable bit zero gates link, resets one.
// - Software clears enable before other edits.
// - Disabled: link reset, serializers, clocks off.
// - Disabled: multiframe counter reset, SYSREF ignored.
// - Calibration enable set before link enable.
// - Link enable cleared before calibration enable.
// - Five-bit output mode field, resets 00010.
// - Mode changes only with both enables low.
// - Multiframe field holds K minus one.
// - Multiframe and control edits only disabled.
// - Writing zero to soft sync requests resync.
// - Soft sync works with any source.
// - Stuck-low sync pin held only with source zero.
// - Source select: pin, differential, or none.
// - Differential source needs timestamp receiver enable.
// - Sample format: offset binary or two's complement.
// - Scrambler enable bit, resets off.
module slcr_regs (
	input  wire logic         clk_i,
	input  wire logic         reset_n_i,
	slcr_if.device            bus,
	input  wire logic         single_ended_sync_pin_n_i,
	input  wire logic         timestamp_diff_input_n_i,
	input  wire logic         sysref_i,
	output logic              link_reset_n_o,
	output logic              serializer_power_o,
	output logic              link_clock_enable_o,
	output logic [4:0]        output_mode_select_o,
	output logic [4:0]        frames_per_multiframe_minus_one_o,
	output logic              sync_request_n_o,
	output logic              sample_format_o,
	output logic              scrambler_enable_o,
	output logic [4:0]        multiframe_count_o
);
	import slcr_pkg::*;

	// ==========================================================
	// Register storage
	logic [7:0] link_enable_reg;
	logic [7:0] link_mode_reg;
	logic [7:0] multiframe_length_reg;
	logic [7:0] soft_sync_request_reg;
	logic [7:0] link_control_reg;
	logic [7:0] rdata_reg;
	logic       rvalid_reg;
	logic [4:0] lmfc_reg;
	logic [4:0] lmfc_next;
	logic       sysref_d_reg;

	wire sel_en   = bus.addr == LINK_ENABLE_ADDR;
	wire sel_mode = bus.addr == LINK_MODE_ADDR;
	wire sel_km   = bus.addr == MULTIFRAME_LEN_ADDR;
	wire sel_sync = bus.addr == SOFT_SYNC_ADDR;
	wire sel_ctrl = bus.addr == LINK_CONTROL_ADDR;
	wire wr       = bus.wr_en;

	// Readback mux; unmapped addresses read zero.
	wire [7:0] rd_mux =
		sel_en   ? link_enable_reg :
		sel_mode ? link_mode_reg :
		sel_km   ? multiframe_length_reg :
		sel_sync ? soft_sync_request_reg :
		sel_ctrl ? link_control_reg : 8'h00;

	wire       link_on  = link_enable_reg[LINK_ENABLE_BIT];
	wire [1:0] sync_sel = link_control_reg[SYNC_SEL_MSB:SYNC_SEL_LSB];
	wire       soft_req = ~soft_sync_request_reg[SOFT_SYNC_BIT];
	// Selected hardware request; source two masks both pins.
	wire hw_req =
		(sync_sel == SYNC_SRC_PIN)  ? ~single_ended_sync_pin_n_i :
		(sync_sel == SYNC_SRC_DIFF) ? ~timestamp_diff_input_n_i :
		1'b0;
	wire sync_req  = soft_req | hw_req;
	wire sysref_rise = sysref_i & ~sysref_d_reg;

	// ==========================================================
	// Register writes
	// Whole bytes stored, reserved bits included.
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			link_enable_reg       <= LINK_ENABLE_RST;
			link_mode_reg         <= LINK_MODE_RST;
			multiframe_length_reg <= MULTIFRAME_LEN_RST;
			soft_sync_request_reg <= SOFT_SYNC_RST;
			link_control_reg      <= LINK_CONTROL_RST;
		end else if (wr) begin
			if (sel_en)
				link_enable_reg <= bus.wdata;
			if (sel_mode)
				link_mode_reg <= bus.wdata;
			if (sel_km)
				multiframe_length_reg <= bus.wdata;
			if (sel_sync)
				soft_sync_request_reg <= bus.wdata;
			if (sel_ctrl)
				link_control_reg <= bus.wdata;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			rdata_reg  <= 8'h00;
			rvalid_reg <= 1'b0;
		end else begin
			rvalid_reg <= bus.rd_en;
			rdata_reg  <= bus.rd_en ? rd_mux : 8'h00;
		end
	end
	assign bus.rdata  = rdata_reg;
	assign bus.rvalid = rvalid_reg;

	// ==========================================================
	// Local multiframe counter
	// Counts frames modulo K; a SYSREF edge realigns it only while on.
	always_comb begin
		lmfc_next = lmfc_reg;
		if (!link_on)
			lmfc_next = 5'h00;
		else if (sysref_rise)
			lmfc_next = 5'h00;
		else if (lmfc_reg == multiframe_length_reg[KM_MSB:0])
			lmfc_next = 5'h00;
		else
			lmfc_next = lmfc_reg + 5'h01;
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			lmfc_reg     <= 5'h00;
			sysref_d_reg <= 1'b0;
		end else begin
			lmfc_reg     <= lmfc_next;
			sysref_d_reg <= sysref_i;
		end
	end

	// ==========================================================
	// Registered outputs
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			link_reset_n_o       <= 1'b0;
			serializer_power_o   <= 1'b0;
			link_clock_enable_o  <= 1'b0;
			output_mode_select_o <= 5'h00;
			frames_per_multiframe_minus_one_o <= 5'h00;
			sync_request_n_o     <= 1'b1;
			sample_format_o      <= 1'b0;
			scrambler_enable_o   <= 1'b0;
			multiframe_count_o   <= 5'h00;
		end else begin
			link_reset_n_o       <= link_on;
			serializer_power_o   <= link_on;
			link_clock_enable_o  <= link_on;
			output_mode_select_o <= link_mode_reg[MODE_MSB:0];
			frames_per_multiframe_minus_one_o <=
				multiframe_length_reg[KM_MSB:0];
			sync_request_n_o     <= ~sync_req;
			sample_format_o      <=
				link_control_reg[SAMPLE_FORMAT_BIT];
			scrambler_enable_o   <=
				link_control_reg[SCRAMBLER_BIT];
			multiframe_count_o   <= lmfc_reg;
		end
	end
endmodule // slcr_regs

// *** hw/slcr_host.sv ***
`timescale 1ns/1ps
// Software-side sequencer: one access per command; it enforces
// the ordering duties of software on the link registers, except clearing calibration while on.
module slcr_host (
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	slcr_if.host             bus,
	input  wire logic        cmd_valid_i,
	input  wire logic        cmd_write_i,
	input  wire logic [11:0] cmd_addr_i,
	input  wire logic [7:0]  cmd_wdata_i,
	input  wire logic        cal_enable_i,
	output logic             cmd_ready_o,
	output logic             cmd_done_o,
	output logic             cmd_refused_o,
	output logic [7:0]       cmd_rdata_o,
	output logic             timestamp_receiver_enable_o
);
	import slcr_pkg::*;

	slcr_host_state_type state_reg;
	logic        link_on_reg;
	logic        wr_reg;
	logic        rd_reg;
	logic [11:0] addr_reg;
	logic [7:0]  wdata_reg;

	wire is_en   = cmd_addr_i == LINK_ENABLE_ADDR;
	wire is_mode = cmd_addr_i == LINK_MODE_ADDR;
	wire is_cfg  = cmd_addr_i == MULTIFRAME_LEN_ADDR ||
	               cmd_addr_i == LINK_CONTROL_ADDR;
	wire en_val  = cmd_wdata_i[LINK_ENABLE_BIT];
	// Refuse writes that break the documented ordering.
	wire bad_en   = is_en & en_val & ~cal_enable_i;
	wire bad_mode = is_mode & (link_on_reg | cal_enable_i);
	wire bad_cfg  = is_cfg & link_on_reg;
	wire refuse   = cmd_write_i & (bad_en | bad_mode | bad_cfg);
	wire take     = cmd_valid_i & (state_reg == ST_IDLE);
	wire ctrl_wr  = cmd_write_i & (cmd_addr_i == LINK_CONTROL_ADDR);
	wire [1:0] new_sel = cmd_wdata_i[SYNC_SEL_MSB:SYNC_SEL_LSB];

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			state_reg     <= ST_IDLE;
			link_on_reg   <= LINK_ENABLE_RST[LINK_ENABLE_BIT];
			wr_reg        <= 1'b0;
			rd_reg        <= 1'b0;
			addr_reg      <= 12'h0000;
			wdata_reg     <= 8'h00;
			cmd_ready_o   <= 1'b0;
			cmd_done_o    <= 1'b0;
			cmd_refused_o <= 1'b0;
			cmd_rdata_o   <= 8'h00;
			timestamp_receiver_enable_o <= 1'b0;
		end else begin
			wr_reg        <= 1'b0;
			rd_reg        <= 1'b0;
			cmd_done_o    <= 1'b0;
			cmd_refused_o <= 1'b0;
			cmd_ready_o   <= 1'b0;
			unique case (state_reg)
				ST_IDLE: begin
					cmd_ready_o <= ~take;
					if (take && refuse) begin
						cmd_refused_o <= 1'b1;
						cmd_ready_o   <= 1'b1;
					end else if (take) begin
						addr_reg  <= cmd_addr_i;
						wdata_reg <= cmd_wdata_i;
						wr_reg    <= cmd_write_i;
						rd_reg    <= ~cmd_write_i;
						state_reg <= cmd_write_i ? ST_WRITE : ST_READ;
						if (cmd_write_i && is_en)
							link_on_reg <= en_val;
						if (ctrl_wr)
							timestamp_receiver_enable_o <=
								new_sel == SYNC_SRC_DIFF;
					end
				end
				ST_WRITE: begin
					cmd_done_o  <= 1'b1;
					cmd_ready_o <= 1'b1;
					state_reg   <= ST_IDLE;
				end
				ST_READ: begin
					if (bus.rvalid) begin
						cmd_rdata_o <= bus.rdata;
						cmd_done_o  <= 1'b1;
						cmd_ready_o <= 1'b1;
						state_reg   <= ST_IDLE;
					end
				end
			endcase
		end
	end
	// Clearing calibration while on is the caller's duty to avoid.
	assign bus.wr_en = wr_reg;
	assign bus.rd_en = rd_reg;
	assign bus.addr  = addr_reg;
	assign bus.wdata = wdata_reg;
endmodule // slcr_host

// *** bench/slcr_props.sv ***
`timescale 1ns/1ps
module slcr_props
	import slcr_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	input  wire logic [11:0] addr,
	input  wire logic [7:0]  wdata,
	input  wire logic [7:0]  rdata,
	input  wire logic        rvalid
);
	// ==========================================
	// Shadow of the link enable bit.
	logic link_on_reg;
	wire  mapped = addr inside {[LINK_ENABLE_ADDR:LINK_CONTROL_ADDR]};
	wire  wr_cfg = wr_en && addr inside {LINK_MODE_ADDR,
		MULTIFRAME_LEN_ADDR, LINK_CONTROL_ADDR};
	always_ff @(posedge clk_i) begin
		if (!reset_n_i)
			link_on_reg <= LINK_ENABLE_RST[LINK_ENABLE_BIT];
		else if (wr_en && addr == LINK_ENABLE_ADDR)
			link_on_reg <= wdata[LINK_ENABLE_BIT];
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	AST_RVALID: assert property (rd_en |=> rvalid)
		else $error("read got no answer");
	AST_NO_SPURIOUS: assert property (!rd_en |=> !rvalid)
		else $error("answer without read");
	AST_RDATA_IDLE: assert property (!rvalid |-> rdata == 8'h00)
		else $error("read data not idle");
	AST_UNMAPPED: assert property (rd_en && !mapped
		|=> rdata == 8'h00)
		else $error("unmapped read not zero");
	AST_ONE_OP: assert property (!(wr_en && rd_en))
		else $error("read and write together");
	AST_CFG_ORDER: assert property (wr_cfg |-> !link_on_reg)
		else $error("config written while link on");
	AST_ENABLE_READ: assert property (rd_en && addr == LINK_ENABLE_ADDR
		|=> rdata[LINK_ENABLE_BIT] == $past(link_on_reg))
		else $error("enable bit readback wrong");
	AST_WRITE_PULSE: assert property (wr_en |=> !wr_en)
		else $error("write strobe held");
endmodule // slcr_props

// *** bench/tb_slcr_regs.sv ***
`timescale 1ns/1ps
module tb_slcr_regs;
	import slcr_pkg::*;
	logic        clk_i = 0;
	logic        reset_n_i = 0;
	logic        cv = 0, cw = 0, cal = 1, pin_n = 1, diff_n = 1, sysref = 0;
	logic [11:0] ca = '0;
	logic [7:0]  cd = '0, rd, rdata, pre;
	logic        ready, done, refused, ts_en, lrst_n, ser_pw, lclk_en, ok;
	logic        sync_n, sfmt, scrambler_enable;
	logic [4:0]  mode, km, mf;
	logic [7:0]  rv [5] = '{8'h01, 8'h02, 8'h1f, 8'h01, 8'h02};
	int          errors = 0;
	int          samples_checked = 0;
	slcr_if bus_if ();
	slcr_regs slcr_regs_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.bus(bus_if.device), .single_ended_sync_pin_n_i(pin_n),
		.timestamp_diff_input_n_i(diff_n), .sysref_i(sysref),
		.link_reset_n_o(lrst_n), .serializer_power_o(ser_pw),
		.link_clock_enable_o(lclk_en), .output_mode_select_o(mode),
		.frames_per_multiframe_minus_one_o(km), .sync_request_n_o(sync_n),
		.sample_format_o(sfmt), .scrambler_enable_o(scrambler_enable),
		.multiframe_count_o(mf));
	slcr_host slcr_host_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.bus(bus_if.host), .cmd_valid_i(cv), .cmd_write_i(cw),
		.cmd_addr_i(ca), .cmd_wdata_i(cd), .cal_enable_i(cal),
		.cmd_ready_o(ready), .cmd_done_o(done), .cmd_refused_o(refused),
		.cmd_rdata_o(rdata), .timestamp_receiver_enable_o(ts_en));
	slcr_props slcr_props_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.wr_en(bus_if.wr_en), .rd_en(bus_if.rd_en), .addr(bus_if.addr),
		.wdata(bus_if.wdata), .rdata(bus_if.rdata), .rvalid(bus_if.rvalid));
	initial begin
		forever #12.5 clk_i = ~clk_i;
	end
	// ==========================================
	// Command tasks.
	task automatic check(input string n, input logic [7:0] s, e);
		samples_checked++;
		if (s !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic tally_and_finish();
		if (errors == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic cmd(input logic w, input logic [11:0] a, input logic [7:0] d);
		for (int n = 0; n < 50 && ready !== 1'b1; n++)
			@(negedge clk_i);
		check("ready", {7'h00, ready}, 8'h01);
		cv = 1;
		cw = w;
		ca = a;
		cd = d;
		@(negedge clk_i);
		cv = 0;
		ok = 0;
		for (int n = 0; n < 10 && done !== 1'b1 && refused !== 1'b1; n++)
			@(negedge clk_i);
		check("answer", {7'h00, done | refused}, 8'h01);
		ok = (done === 1'b1);
		rd = rdata;
		repeat (3) @(negedge clk_i);
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic e);
		cmd(1'b1, a, d);
		check("accepted", {7'h00, ok}, {7'h00, e});
	endtask
	task automatic rdc(input logic [11:0] a, input logic [7:0] e);
		cmd(1'b0, a, 8'h00);
		check("readback", rd, e);
	endtask
	task automatic settle();
		repeat (3) @(negedge clk_i);
	endtask
	initial begin
		repeat (20) @(negedge clk_i);
		reset_n_i = 1;
		@(negedge clk_i);
		for (int i = 0; i < 5; i++)
			rdc(LINK_ENABLE_ADDR + 12'(i), rv[i]);
		check("link on", {5'h00, lrst_n, ser_pw, lclk_en}, 8'h07);
		check("mode", {3'h0, mode}, 8'h02);
		check("km", {3'h0, km}, 8'h1f);
		check("fmt scr", {6'h00, sfmt, scrambler_enable}, 8'h02);
		rdc(12'h0205, 8'h00);
		wr(LINK_MODE_ADDR, 8'h05, 1'b0);
		wr(MULTIFRAME_LEN_ADDR, 8'h07, 1'b0);
		wr(LINK_ENABLE_ADDR, 8'h00, 1'b1);
		check("link off", {5'h00, lrst_n, ser_pw, lclk_en}, 8'h00);
		sysref = 1;
		settle();
		sysref = 0;
		check("lmfc held", {3'h0, mf}, 8'h00);
		wr(LINK_MODE_ADDR, 8'hb5, 1'b0);
		cal = 0;
		wr(LINK_MODE_ADDR, 8'hb5, 1'b1);
		check("mode", {3'h0, mode}, 8'h15);
		rdc(LINK_MODE_ADDR, 8'hb5);
		wr(MULTIFRAME_LEN_ADDR, 8'he7, 1'b1);
		check("km", {3'h0, km}, 8'h07);
		rdc(MULTIFRAME_LEN_ADDR, 8'he7);
		wr(LINK_CONTROL_ADDR, 8'h09, 1'b1);
		check("fmt scr", {6'h00, sfmt, scrambler_enable}, 8'h01);
		pin_n = 0;
		settle();
		check("sync masked", {7'h00, sync_n}, 8'h01);
		wr(SOFT_SYNC_ADDR, 8'h00, 1'b1);
		check("soft sync", {7'h00, sync_n}, 8'h00);
		wr(SOFT_SYNC_ADDR, 8'h01, 1'b1);
		wr(LINK_CONTROL_ADDR, 8'h02, 1'b1);
		check("pin sync", {7'h00, sync_n}, 8'h00);
		pin_n = 1;
		settle();
		check("pin idle", {7'h00, sync_n}, 8'h01);
		wr(LINK_CONTROL_ADDR, 8'h06, 1'b1);
		check("ts enable", {7'h00, ts_en}, 8'h01);
		diff_n = 0;
		settle();
		check("diff sync", {7'h00, sync_n}, 8'h00);
		pin_n = 0;
		wr(LINK_CONTROL_ADDR, 8'h0e, 1'b1);
		check("sel three", {7'h00, sync_n}, 8'h01);
		check("ts disable", {7'h00, ts_en}, 8'h00);
		pin_n = 1;
		diff_n = 1;
		wr(LINK_ENABLE_ADDR, 8'h01, 1'b0);
		cal = 1;
		wr(LINK_ENABLE_ADDR, 8'h01, 1'b1);
		check("link on", {5'h00, lrst_n, ser_pw, lclk_en}, 8'h07);
		pre = {3'h0, mf};
		@(negedge clk_i);
		check("lmfc step", {3'h0, mf}, (pre + 8'h01) & 8'h07);
		repeat (7) @(negedge clk_i);
		check("lmfc wrap", {3'h0, mf}, pre);
		wr(LINK_ENABLE_ADDR, 8'h00, 1'b1);
		cal = 0;
		tally_and_finish();
	end
	initial begin
		repeat (5000) @(posedge clk_i);
		errors++;
		tally_and_finish();
	end
endmodule // tb_slcr_regs
